// file: p2p_seq_pkg.sv
/*
 * Shared constants and types for the point-to-point program sequencer:
 * register offsets, field positions, reset values, timing and states.
 * Assumes a 100 MHz mclk and a 32-bit APB register bus.
 */
package p2p_seq_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_RSVD_A   = 12'h000;
    localparam logic [11:0] OFF_SEQ_CFG  = 12'h004;
    localparam logic [11:0] OFF_COORD    = 12'h008;
    localparam logic [11:0] OFF_FIRST    = 12'h00C;
    localparam logic [11:0] OFF_LAST     = 12'h010;
    localparam logic [11:0] OFF_STATUS   = 12'h014;
    localparam logic [11:0] OFF_STOP_TAB = 12'h040;  // 16 words of stop time
    localparam logic [11:0] STOP_TAB_MSK = 12'hFC0;

    // Field positions inside sequence_mode_config
    localparam int SEL_LSB   = 0;
    localparam int MODE_LSB  = 4;
    localparam int SENSE_LSB = 8;
    localparam logic [15:0] CFG_MASK = 16'h0133;

    // Reset values
    localparam logic [15:0] CFG_RST   = 16'h0000;
    localparam logic        COORD_RST = 1'h0;
    localparam logic [3:0]  FIRST_RST = 4'h0;
    localparam logic [3:0]  LAST_RST  = 4'hF;
    localparam logic [15:0] STOP_RST  = 16'h0000;

    // Timing: stop times and the start delay count in 50 ms units
    localparam int CLK_HZ          = 100_000_000;
    localparam int UNIT_MS         = 50;
    localparam int UNIT_CYCLES_DEF = UNIT_MS * (CLK_HZ / 1000);
    localparam logic [15:0] START_DELAY_UNITS = 16'h0001;

    typedef enum logic [2:0] {
        S_IDLE, S_START_DELAY, S_ISSUE, S_MOVING, S_DWELL, S_WAIT_STEP, S_DONE
    } seq_state_e;

    // Decoded view of the mode settings
    typedef struct packed {
        logic [1:0] start_sel;
        logic [1:0] step_mode;
        logic       pulse_sense;
        logic       abs_coord;
        logic [3:0] first;
        logic [3:0] last;
    } seq_cfg_s;
endpackage

// file: stop_time_mem.sv
/*
 * Per-step stop time table, 16 words of 16 bits, one write port and two
 * registered read ports. Assumes writes come from the register slave.
 */
`timescale 1ns/1ps
module stop_time_mem (
    input  wire logic        mclk,
    input  wire logic        clk_en,
    input  wire logic        we,
    input  wire logic [3:0]  waddr,
    input  wire logic [15:0] wdata,
    input  wire logic [3:0]  raddr_a,
    output logic      [15:0] rdata_a,
    input  wire logic [3:0]  raddr_b,
    output logic      [15:0] rdata_b
);
    logic [15:0] mem [16];

    // No reset on the array; software loads it before starting a program
    always_ff @(posedge mclk) begin
        if (clk_en) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end
endmodule // stop_time_mem

// file: p2p_sequencer.sv
/*
 * Point-to-point program sequencer: APB registers, pin synchronisers,
 * start/search decoding and the step state machine.
 * Assumes the pulse generator takes step_go/step_index and returns
 * move_done on mclk; the four drive inputs are asynchronous pins.
 */
`timescale 1ns/1ps
// How it works
// RULE1: Select 0 cyclic, 1 single; forward limit starts, reverse limit searches.
// RULE2: Select 2 cyclic, 3 single; reverse limit starts, forward limit searches.
// RULE3: Mode 0 advances on delay, no start input, begins after delay past servo-on.
// RULE4: Mode 1 advances on step input; pulses keep going when it drops.
// RULE5: Mode 2 advances on delay, needs start; dropping start stops pulses now.
// RULE6: Mode 3 advances on step input, needs start; dropping start stops pulses now.
// RULE7: Modes 2 and 3 return to the first step on a reset.
// RULE8: Step input sensed by level when field is 0, by edge when 1.
// RULE9: Coordinate 0 means incremental targets, 1 means absolute targets.
// RULE10: The program begins at the first-step index.
// RULE11: The last-step index is the final step of the program.
// RULE12: Delay advance waits the step's stop time in 50 ms units.
// RULE13: Cyclic wraps last to first; single halts after the last step.
// RULE14: Settings act at once when written, no restart needed.
module p2p_sequencer #(
    parameter int UNIT_CYCLES = p2p_seq_pkg::UNIT_CYCLES_DEF
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        forward_limit_input,
    input  wire logic        reverse_limit_input,
    input  wire logic        step_advance_input,
    input  wire logic        servo_on_input,
    input  wire logic        move_done,
    output logic      [3:0]  step_index,
    output logic             step_go,
    output logic             pulse_enable,
    output logic             abs_mode,
    output logic             search_req,
    output logic             program_done
);
    // Register storage
    logic [15:0] seq_cfg;
    logic        coord;
    logic [3:0]  first_step;
    logic [3:0]  last_step;
    logic [15:0] tab_rdata;
    logic [15:0] stop_time;
    p2p_seq_pkg::seq_cfg_s cfg;
    p2p_seq_pkg::seq_state_e state;
    p2p_seq_pkg::seq_state_e next_state;

    // APB decode
    wire wr_en    = psel & penable & pready & pwrite;
    wire hit_rsvd = (paddr == p2p_seq_pkg::OFF_RSVD_A);
    wire hit_cfg  = (paddr == p2p_seq_pkg::OFF_SEQ_CFG);
    wire hit_crd  = (paddr == p2p_seq_pkg::OFF_COORD);
    wire hit_fst  = (paddr == p2p_seq_pkg::OFF_FIRST);
    wire hit_lst  = (paddr == p2p_seq_pkg::OFF_LAST);
    wire hit_sts  = (paddr == p2p_seq_pkg::OFF_STATUS);
    wire hit_tab  = ((paddr & p2p_seq_pkg::STOP_TAB_MSK) == p2p_seq_pkg::OFF_STOP_TAB)
                    && (paddr[1:0] == 2'h0);
    wire hit_any  = hit_rsvd | hit_cfg | hit_crd | hit_fst | hit_lst | hit_sts | hit_tab;
    wire [31:0] status_word = {25'h000000, pulse_enable, program_done,
                               (state != p2p_seq_pkg::S_IDLE), step_index};
    wire [31:0] rd_mux = hit_cfg ? {16'h0000, seq_cfg} :
                         hit_crd ? {31'h0000000, coord} :
                         hit_fst ? {28'h0000000, first_step} :
                         hit_lst ? {28'h0000000, last_step} :
                         hit_sts ? status_word :
                         hit_tab ? {16'h0000, tab_rdata} : 32'h00000000;

    // One wait state: table read data needs a cycle after setup
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & penable & ~pready;
            prdata  <= rd_mux;
            pslverr <= ~hit_any;
        end
    end

    // Settings registers; used live by the sequencer
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_cfg    <= p2p_seq_pkg::CFG_RST;
            coord      <= p2p_seq_pkg::COORD_RST;
            first_step <= p2p_seq_pkg::FIRST_RST;
            last_step  <= p2p_seq_pkg::LAST_RST;
        end else if (clk_en && wr_en) begin  // see RULE14
            if (hit_cfg) seq_cfg <= pwdata[15:0] & p2p_seq_pkg::CFG_MASK;
            if (hit_crd) coord <= pwdata[0];
            if (hit_fst) first_step <= pwdata[3:0];
            if (hit_lst) last_step <= pwdata[3:0];
        end
    end

    stop_time_mem u_stop_mem (
        .mclk    (mclk),
        .clk_en  (clk_en),
        .we      (wr_en & hit_tab),
        .waddr   (paddr[5:2]),
        .wdata   (pwdata[15:0]),
        .raddr_a (paddr[5:2]),
        .rdata_a (tab_rdata),
        .raddr_b (step_index),
        .rdata_b (stop_time)
    );

    // Decoded configuration
    assign cfg.start_sel   = seq_cfg[p2p_seq_pkg::SEL_LSB +: 2];
    assign cfg.step_mode   = seq_cfg[p2p_seq_pkg::MODE_LSB +: 2];
    assign cfg.pulse_sense = seq_cfg[p2p_seq_pkg::SENSE_LSB];
    assign cfg.abs_coord   = coord;
    assign cfg.first       = first_step;
    assign cfg.last        = last_step;

    // Two-stage synchronisers; only the second stage is read
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] pin_prev;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            pin_prev <= 4'h0;
        end else if (clk_en) begin
            pin_meta <= {servo_on_input, step_advance_input,
                         reverse_limit_input, forward_limit_input};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    wire fwd_lvl  = pin_sync[0];
    wire rev_lvl  = pin_sync[1];
    wire step_lvl = pin_sync[2];
    wire son      = pin_sync[3];
    wire fwd_rise = pin_sync[0] & ~pin_prev[0];
    wire rev_rise = pin_sync[1] & ~pin_prev[1];
    wire step_rise = pin_sync[2] & ~pin_prev[2];
    wire son_fell = ~pin_sync[3] & pin_prev[3];

    // Start/search pin swap and run options
    wire sel_swap   = cfg.start_sel[1];                     // see RULE1 see RULE2
    wire cyclic     = ~cfg.start_sel[0];                    // see RULE1 see RULE2
    wire start_lvl  = sel_swap ? rev_lvl : fwd_lvl;         // see RULE1 see RULE2
    wire search_hit = sel_swap ? fwd_rise : rev_rise;       // see RULE1 see RULE2
    wire need_start = cfg.step_mode[1];                     // see RULE5 see RULE6
    wire step_by_in = cfg.step_mode[0];                     // see RULE3 see RULE4
    // Without a start input the program only waits for servo-on
    wire allowed    = son & (~need_start | start_lvl);      // see RULE5 see RULE6
    wire step_trig  = cfg.pulse_sense ? step_rise : step_lvl;  // see RULE8
    wire at_last    = (step_index == cfg.last);             // see RULE11

    // Next index, wrapping at the last step
    function automatic logic [3:0] advance(input logic [3:0] cur, input logic [3:0] fst,
                                           input logic [3:0] lst);
        advance = (cur == lst) ? fst : cur + 4'h1;
    endfunction

    // 50 ms unit timer and unit counter shared by start delay and dwell
    logic [31:0] tick_cnt;
    logic [15:0] unit_cnt;
    wire timing   = (state == p2p_seq_pkg::S_START_DELAY) | (state == p2p_seq_pkg::S_DWELL);
    wire unit_end = (tick_cnt == 32'(UNIT_CYCLES - 1));
    wire [15:0] wait_units = (state == p2p_seq_pkg::S_DWELL) ? stop_time :
                             p2p_seq_pkg::START_DELAY_UNITS;
    wire wait_over = (unit_cnt >= wait_units);              // see RULE12

    // Counting pauses while pulses are withheld; restarts on each wait
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt <= 32'h00000000;
            unit_cnt <= 16'h0000;
        end else if (clk_en) begin
            if (!timing || next_state != state) begin
                tick_cnt <= 32'h00000000;
                unit_cnt <= 16'h0000;
            end else if (allowed && !wait_over) begin
                tick_cnt <= unit_end ? 32'h00000000 : tick_cnt + 32'h00000001;
                if (unit_end) unit_cnt <= unit_cnt + 16'h0001;  // see RULE12
            end
        end
    end

    // Step state machine
    always_comb begin
        next_state = state;
        case (state)
            p2p_seq_pkg::S_IDLE:
                if (allowed) next_state = p2p_seq_pkg::S_START_DELAY;  // see RULE3 see RULE4
            // A withdrawn start also holds back the first step
            p2p_seq_pkg::S_START_DELAY:
                if (wait_over && allowed) next_state = p2p_seq_pkg::S_ISSUE;  // see RULE6
            p2p_seq_pkg::S_ISSUE:
                next_state = p2p_seq_pkg::S_MOVING;
            p2p_seq_pkg::S_MOVING:
                if (move_done) begin
                    if (at_last && !cyclic) begin
                        next_state = p2p_seq_pkg::S_DONE;               // see RULE13
                    end else if (step_by_in) begin
                        next_state = p2p_seq_pkg::S_WAIT_STEP;          // see RULE4 see RULE6
                    end else begin
                        next_state = p2p_seq_pkg::S_DWELL;              // see RULE3 see RULE5
                    end
                end
            p2p_seq_pkg::S_DWELL:
                if (wait_over && allowed) next_state = p2p_seq_pkg::S_ISSUE;
            p2p_seq_pkg::S_WAIT_STEP:
                if (step_trig && allowed) next_state = p2p_seq_pkg::S_ISSUE;  // see RULE8
            p2p_seq_pkg::S_DONE:
                next_state = p2p_seq_pkg::S_DONE;
            default:
                next_state = p2p_seq_pkg::S_IDLE;
        endcase
        // Servo-off ends the program; the step kept depends on the mode
        if (!son) next_state = p2p_seq_pkg::S_IDLE;
    end

    wire leaving_wait = ((state == p2p_seq_pkg::S_DWELL) | (state == p2p_seq_pkg::S_WAIT_STEP))
                        && (next_state == p2p_seq_pkg::S_ISSUE);
    wire [3:0] next_step_index =
        (son_fell && need_start)                 ? cfg.first :            // see RULE7
        (state == p2p_seq_pkg::S_IDLE && allowed) ? cfg.first :           // see RULE10
        leaving_wait ? advance(step_index, cfg.first, cfg.last) :         // see RULE13
        step_index;

    // Modes 0 and 1 hold the step index over a servo-off; the start
    // from idle reloads it anyway, so only status readback differs
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state        <= p2p_seq_pkg::S_IDLE;
            step_index   <= p2p_seq_pkg::FIRST_RST;
            step_go      <= 1'b0;
            pulse_enable <= 1'b0;
            abs_mode     <= p2p_seq_pkg::COORD_RST;
            search_req   <= 1'b0;
            program_done <= 1'b0;
        end else if (clk_en) begin
            state        <= next_state;
            step_index   <= next_step_index;
            step_go      <= (next_state == p2p_seq_pkg::S_ISSUE);
            // Dropping the step input never gates pulses; start, servo-on and the idle and done states do
            pulse_enable <= allowed && (state != p2p_seq_pkg::S_IDLE)
                            && (state != p2p_seq_pkg::S_DONE);  // see RULE4 see RULE5 see RULE6
            abs_mode     <= cfg.abs_coord;                       // see RULE9
            search_req   <= son & search_hit;                    // see RULE1 see RULE2
            program_done <= (next_state == p2p_seq_pkg::S_DONE);
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst || !clk_en);

    // Pin roles follow the select field
    a_search_reverse: assert property (!sel_swap && rev_rise && son ##1 clk_en |-> search_req) // see RULE1
        else $error("reverse limit did not raise search");
    a_search_forward: assert property (sel_swap && fwd_rise && son ##1 clk_en |-> search_req) // see RULE2
        else $error("forward limit did not raise search");
    // Start, stop and step rules
    a_nostart_runs: assert property ((state == p2p_seq_pkg::S_IDLE) // see RULE3
                                     && son && !need_start ##1 clk_en
                                     |-> state == p2p_seq_pkg::S_START_DELAY)
        else $error("program did not begin after servo-on");
    a_start_cut: assert property (need_start && !start_lvl ##1 clk_en |-> !pulse_enable) // see RULE5
        else $error("pulses not stopped when start removed");
    a_start_cut_step: assert property (step_by_in && need_start && son && !start_lvl // see RULE6
                                       ##1 clk_en |-> !pulse_enable && !step_go)
        else $error("pulses not stopped in step-input mode");
    a_step_hold: assert property (step_by_in && !need_start && son // see RULE4
                                  && $fell(step_lvl) && (state == p2p_seq_pkg::S_MOVING)
                                  ##1 clk_en |-> pulse_enable)
        else $error("step input drop halted pulses");
    a_reset_first: assert property (son_fell && need_start ##1 clk_en // see RULE7
                                    |-> step_index == $past(first_step))
        else $error("reset did not return to first step");
    a_level_sense: assert property ((state == p2p_seq_pkg::S_WAIT_STEP) // see RULE8
                                    && !cfg.pulse_sense && step_lvl && allowed
                                    ##1 clk_en |-> step_go)
        else $error("level step input did not advance");
    a_coord_follow: assert property (##1 clk_en |-> abs_mode == $past(coord)) // see RULE9
        else $error("coordinate mode not followed");
    a_first_load: assert property ((state == p2p_seq_pkg::S_IDLE) && allowed // see RULE10
                                   ##1 clk_en |-> step_index == $past(first_step))
        else $error("program did not begin at first step");
    a_single_end: assert property ((state == p2p_seq_pkg::S_MOVING) && move_done // see RULE11
                                   && at_last && !cyclic && son ##1 clk_en |-> program_done)
        else $error("single run did not halt at last step");
    a_dwell_wait: assert property ((state == p2p_seq_pkg::S_DWELL) && !wait_over // see RULE12
                                   |-> next_state != p2p_seq_pkg::S_ISSUE)
        else $error("dwell ended before stop time");
    a_cyclic_wrap: assert property (leaving_wait && at_last && son ##1 clk_en // see RULE13
                                    |-> step_index == $past(first_step))
        else $error("cyclic run did not wrap");
    a_cfg_live: assert property (wr_en && hit_cfg ##1 clk_en // see RULE14
                                 |-> seq_cfg == ($past(pwdata[15:0]) & p2p_seq_pkg::CFG_MASK))
        else $error("setting not applied at once");

    // Bus timing: one wait state, ready for one cycle only
    a_apb_wait: assert property (psel && !penable ##1 clk_en |-> !pready) // see RULE14
        else $error("ready came in the setup cycle");
    a_ready_pulse: assert property (pready ##1 clk_en |-> !pready) // see RULE14
        else $error("ready held for two cycles");
    a_slverr_map: assert property (psel && penable && !pready && !hit_any // see RULE14
                                   ##1 clk_en |-> pready && pslverr)
        else $error("unmapped address not refused");

    // A withheld start freezes the timers and the first step
    a_delay_hold: assert property ((state == p2p_seq_pkg::S_START_DELAY) && !allowed // see RULE6
                                   ##1 clk_en |-> !step_go)
        else $error("step issued without start");
    a_dwell_pause: assert property ((state == p2p_seq_pkg::S_DWELL) && !allowed // see RULE5
                                    && son ##1 clk_en |-> $stable(unit_cnt))
        else $error("stop time ran on without start");
    a_step_pulse: assert property (step_go ##1 clk_en |-> !step_go) // see RULE3
        else $error("step request held two cycles");
    a_servo_off: assert property (!son ##1 clk_en |-> state == p2p_seq_pkg::S_IDLE) // see RULE3
        else $error("program ran on after servo-off");

    // Single run: done holds and pulses stay off
    a_done_quiet: assert property (program_done ##1 clk_en |-> !pulse_enable) // see RULE13
        else $error("pulses enabled after program end");
    a_done_stay: assert property (program_done && son ##1 clk_en |-> program_done) // see RULE13
        else $error("program end flag dropped");

    // Main scenarios
    c_wrap: cover property (leaving_wait && at_last);
    c_step_issued: cover property (step_go);
    c_dwell_done: cover property ((state == p2p_seq_pkg::S_DWELL) ##1 step_go);
    c_single_done: cover property ($rose(program_done));
    c_search: cover property (search_req);
endmodule // p2p_sequencer

// file: p2p_motion_partner.sv
/*
 * Stand-in for the pulse generator: answers each step_go with move_done.
 * Assumes step_go and pulse_enable come from the sequencer on mclk.
 */
`timescale 1ns/1ps
module p2p_motion_partner (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       step_go,
    input  wire logic       pulse_enable,
    input  wire logic [7:0] move_len,
    output logic            move_done
);
    logic [7:0] remain;

    // Motion only progresses while pulses are allowed, so a stop holds it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            remain    <= 8'h00;
            move_done <= 1'b0;
        end else begin
            move_done <= pulse_enable && remain == 8'h01;
            if (step_go)
                remain <= move_len;
            else if (pulse_enable && remain != 8'h00)
                remain <= remain - 8'h01;
        end
    end
endmodule // p2p_motion_partner

// file: test_p2p_sequencer.sv
/*
 * Self-checking bench for the sequencer: APB set-up, pin stimulus, step checks.
 * Assumes the design package and the motion partner are compiled first.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED %0t got %0h exp %0h", $time, a, b); end end
module test_p2p_sequencer;
    localparam int UC = 4;
    logic        mclk    = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h00000000;
    logic        fwd = 1'b0, rev = 1'b0, stp = 1'b0, son = 1'b0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, move_done, step_go, pulse_enable;
    logic        abs_mode, search_req, program_done;
    logic [3:0]  step_index, idx;
    logic [7:0]  mlen    = 8'h02;
    int          errors = 0, cmp_count = 0, n, g1, g2;

    initial begin
        forever #5 mclk = ~mclk;
    end

    p2p_sequencer #(.UNIT_CYCLES(UC)) DUT (
        .mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .forward_limit_input(fwd), .reverse_limit_input(rev),
        .step_advance_input(stp), .servo_on_input(son), .move_done(move_done),
        .step_index(step_index), .step_go(step_go), .pulse_enable(pulse_enable),
        .abs_mode(abs_mode), .search_req(search_req), .program_done(program_done));

    p2p_motion_partner PM (
        .mclk(mclk), .sys_rst(sys_rst), .step_go(step_go),
        .pulse_enable(pulse_enable), .move_len(mlen), .move_done(move_done));

    task automatic end_sim();
        $display("Errors %0d, compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A wait that ran out of cycles counts as a mismatch
    task automatic hang();
        errors++;
        $display("CHECK FAILED %0t wait ran out", $time);
        end_sim();
    endtask

    // One APB transfer, held until pready is sampled high; idle cycle after
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50)
            hang();
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    // Next step_go: its index and the cycles waited
    task automatic go(output logic [3:0] i, output int g);
        g = 0;
        do begin
            @(posedge mclk);
            g++;
        end while (step_go !== 1'b1 && g < 400);
        if (g >= 400)
            hang();
        i = step_index;
    endtask

    // Pulses seen on a design output over a window
    task automatic count(ref logic s, input int c, output int k);
        k = 0;
        repeat (c) begin
            @(posedge mclk);
            if (s === 1'b1)
                k++;
        end
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        // Reset values, field mask and a refused address
        apb(1'b0, p2p_seq_pkg::OFF_LAST, 32'h00000000);
        `CHK(rd, {28'h0000000, p2p_seq_pkg::LAST_RST})
        apb(1'b0, p2p_seq_pkg::OFF_RSVD_A, 32'h00000000);
        `CHK(rd, 32'h00000000)
        apb(1'b0, 12'h020, 32'h00000000);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b1, p2p_seq_pkg::OFF_SEQ_CFG, 32'hFFFFFFFF);
        apb(1'b0, p2p_seq_pkg::OFF_SEQ_CFG, 32'h00000000);
        `CHK(rd, {16'h0000, p2p_seq_pkg::CFG_MASK})
        apb(1'b1, p2p_seq_pkg::OFF_COORD, 32'h00000001);
        repeat (2) @(posedge mclk);
        `CHK(abs_mode, 1'b1)
        apb(1'b1, p2p_seq_pkg::OFF_COORD, 32'h00000000);
        repeat (2) @(posedge mclk);
        `CHK(abs_mode, 1'b0)
        // Delay advance, cyclic, steps 2..3; step 2 dwells two units
        apb(1'b1, p2p_seq_pkg::OFF_SEQ_CFG, 32'h00000000);
        apb(1'b1, p2p_seq_pkg::OFF_FIRST, 32'h00000002);
        apb(1'b1, p2p_seq_pkg::OFF_LAST, 32'h00000003);
        apb(1'b1, p2p_seq_pkg::OFF_STOP_TAB + 12'h004, 32'h00000000);
        apb(1'b1, p2p_seq_pkg::OFF_STOP_TAB + 12'h008, 32'h00000002);
        apb(1'b1, p2p_seq_pkg::OFF_STOP_TAB + 12'h00C, 32'h00000000);
        son <= 1'b1;
        go(idx, n);
        `CHK(idx, 4'h2)
        go(idx, g1);
        `CHK(idx, 4'h3)
        go(idx, g2);
        `CHK(idx, 4'h2)
        `CHK(g1 - g2 >= 2 * UC - 1 && g1 - g2 <= 2 * UC + 1, 1'b1)
        // Switch to single mid-run: stops after the last step
        apb(1'b1, p2p_seq_pkg::OFF_SEQ_CFG, 32'h00000001);
        go(idx, n);
        `CHK(idx, 4'h3)
        count(step_go, 40, n);
        `CHK(n, 0)
        `CHK(program_done, 1'b1)
        `CHK(pulse_enable, 1'b0)
        // Search pin follows the select field
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, p2p_seq_pkg::OFF_SEQ_CFG, 32'(s));
            if (s < 2)
                rev <= 1'b1;
            else
                fwd <= 1'b1;
            count(search_req, 8, n);
            `CHK(n, 1)
            rev <= 1'b0;
            fwd <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        son <= 1'b0;
        repeat (6) @(posedge mclk);
        // Delay advance needing start on the reverse pin, steps 1..3
        apb(1'b1, p2p_seq_pkg::OFF_FIRST, 32'h00000001);
        apb(1'b1, p2p_seq_pkg::OFF_SEQ_CFG, 32'h00000022);
        son <= 1'b1;
        count(step_go, 40, n);
        `CHK(n, 0)
        rev <= 1'b1;
        go(idx, n);
        `CHK(idx, 4'h1)
        go(idx, n);
        `CHK(idx, 4'h2)
        rev <= 1'b0;
        repeat (5) @(posedge mclk);
        `CHK(pulse_enable, 1'b0)
        count(step_go, 40, n);
        `CHK(n, 0)
        son <= 1'b0;
        repeat (6) @(posedge mclk);
        `CHK(step_index, 4'h1)
        // Step input, edge sensed, held high before servo-on
        apb(1'b1, p2p_seq_pkg::OFF_FIRST, 32'h00000000);
        apb(1'b1, p2p_seq_pkg::OFF_SEQ_CFG, 32'h00000110);
        stp <= 1'b1;
        repeat (4) @(posedge mclk);
        son <= 1'b1;
        go(idx, n);
        `CHK(idx, 4'h0)
        count(step_go, 40, n);
        `CHK(n, 0)
        stp <= 1'b0;
        repeat (5) @(posedge mclk);
        `CHK(pulse_enable, 1'b1)
        stp <= 1'b1;
        go(idx, n);
        `CHK(idx, 4'h1)
        // Dropping the step input mid-move leaves pulses on
        stp <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK(pulse_enable, 1'b1)
        stp <= 1'b1;
        // Level sensing: a held input keeps stepping
        apb(1'b1, p2p_seq_pkg::OFF_SEQ_CFG, 32'h00000010);
        count(step_go, 60, n);
        `CHK(n > 2, 1'b1)
        son <= 1'b0;
        repeat (6) @(posedge mclk);
        // Step input with start on the reverse pin, single run
        apb(1'b1, p2p_seq_pkg::OFF_SEQ_CFG, 32'h00000033);
        son <= 1'b1;
        count(step_go, 40, n);
        `CHK(n, 0)
        rev <= 1'b1;
        go(idx, n);
        `CHK(idx, 4'h0)
        rev <= 1'b0;
        repeat (5) @(posedge mclk);
        `CHK(pulse_enable, 1'b0)
        end_sim();
    end
endmodule // test_p2p_sequencer
